// file: src/lts_pkg.sv
// constants and address conversion for local connection setup
package lts_pkg;

    // ------------------------------------------------------------
    // memory geometry
    // ------------------------------------------------------------
    localparam int LTS_IDX_W = 10;
    localparam int LTS_DEPTH = 1024;
    localparam int LTS_ENTRY_W = 15;

    // ------------------------------------------------------------
    // rate codes and slot limits
    // ------------------------------------------------------------
    localparam logic [1:0] LTS_RATE_2M = 2'h0;
    localparam logic [1:0] LTS_RATE_4M = 2'h1;
    localparam logic [1:0] LTS_RATE_8M = 2'h2;
    localparam logic [6:0] LTS_SLOT_MAX_2M = 7'h1F;
    localparam logic [6:0] LTS_SLOT_MAX_4M = 7'h3F;
    localparam logic [6:0] LTS_SLOT_MAX_8M = 7'h7F;
    localparam logic [3:0] LTS_STREAM_MAX_8M = 4'h7;

    // ------------------------------------------------------------
    // address mode register fields
    // ------------------------------------------------------------
    localparam int LTS_MODE_STREAM_LSB = 0;
    localparam int LTS_MODE_FIELD_LSB = 4;
    localparam logic [3:0] LTS_FIELD_SLOT = 4'h0;
    localparam logic [3:0] LTS_FIELD_CTRL = 4'h1;

    // ------------------------------------------------------------
    // second transfer layout
    // ------------------------------------------------------------
    localparam int LTS_BIT_XSTROBE = 7;
    localparam int LTS_BIT_PATTERN = 6;
    localparam int LTS_BIT_ALTBUF = 5;
    localparam int LTS_BIT_SLOT_OE = 4;
    localparam int LTS_SRC_STREAM_LSB = 0;

    // ------------------------------------------------------------
    // entry layout: {xcs,pme,fme,che,stream[3:0],slot[6:0]}
    // ------------------------------------------------------------
    localparam int LTS_E_XSTROBE = 14;
    localparam int LTS_E_PATTERN = 13;
    localparam int LTS_E_ALTBUF = 12;
    localparam int LTS_E_SLOT_OE = 11;
    localparam int LTS_E_STREAM_LSB = 7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] LTS_SLOT_RST = 8'h00;
    localparam logic [7:0] LTS_MODE_RST = 8'h00;
    localparam logic [7:0] LTS_HOLD_RST = 8'h00;

    // stream/slot to physical index; 2M leaves the top half unused
    function automatic logic [LTS_IDX_W-1:0] lts_phys_idx(input logic [1:0] rate,
                                                           input logic [3:0] stream,
                                                           input logic [6:0] slot);
        logic [LTS_IDX_W-1:0] idx;
        idx = '0;
        case (rate)
            LTS_RATE_8M: idx = {stream[2:0], slot[6:0]};
            LTS_RATE_4M: idx = {stream[3:0], slot[5:0]};
            default: idx = {1'b0, stream[3:0], slot[4:0]};
        endcase
        return idx;
    endfunction : lts_phys_idx

    function automatic logic lts_addr_ok(input logic [1:0] rate,
                                         input logic [3:0] stream,
                                         input logic [6:0] slot);
        logic ok;
        ok = 1'b0;
        case (rate)
            LTS_RATE_2M: ok = (slot <= LTS_SLOT_MAX_2M);
            LTS_RATE_4M: ok = (slot <= LTS_SLOT_MAX_4M);
            LTS_RATE_8M: ok = (slot <= LTS_SLOT_MAX_8M) && (stream <= LTS_STREAM_MAX_8M);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : lts_addr_ok

    typedef enum logic [0:0] {LTS_IDLE, LTS_HALF} lts_state_t;

endpackage : lts_pkg

// file: src/lts_mem_if.sv
// carrier between setup control and switching datapath
`timescale 1ns/1ps
`default_nettype none
interface lts_mem_if;
    import lts_pkg::*;
    logic cm_we;
    logic [LTS_IDX_W-1:0] cm_idx;
    logic [LTS_ENTRY_W-1:0] cm_entry;
    logic dm_we;
    logic [LTS_IDX_W-1:0] dm_idx;
    logic [7:0] dm_byte;
    logic rd_req;
    logic [LTS_IDX_W-1:0] rd_idx;
    logic [1:0] rate;
    logic rd_valid;
    logic [7:0] rd_byte;
    logic rd_oe_n;
    logic rd_strobe;
    logic rd_altbuf;

    modport ctl (output cm_we, cm_idx, cm_entry, dm_we, dm_idx, dm_byte, rd_req, rd_idx, rate,
                 input rd_valid, rd_byte, rd_oe_n, rd_strobe, rd_altbuf);
    modport sw (input cm_we, cm_idx, cm_entry, dm_we, dm_idx, dm_byte, rd_req, rd_idx, rate,
                output rd_valid, rd_byte, rd_oe_n, rd_strobe, rd_altbuf);
endinterface : lts_mem_if
`default_nettype wire

// file: src/lts_switch.sv
// connection and data memories with the output slot read path
`timescale 1ns/1ps
`default_nettype none
module lts_switch
    import lts_pkg::*;
(
    input wire logic clk_sys, // system clock
    input wire logic rst, // sync reset, high
    lts_mem_if.sw mif // memory ports
);
    logic [LTS_ENTRY_W-1:0] conn_mem [LTS_DEPTH];
    logic [7:0] data_mem [LTS_DEPTH];
    logic [LTS_ENTRY_W-1:0] entry_ff;
    logic [7:0] dbyte_ff;
    logic [LTS_ENTRY_W-1:0] entry2_ff;
    logic v1_ff;
    logic v2_ff;
    logic valid_ff;
    logic [7:0] byte_ff;
    logic oe_n_ff;
    logic strobe_ff;
    logic altbuf_ff;

    // ------------------------------------------------------------
    // memories
    // ------------------------------------------------------------
    // [R1] 1024-entry stores
    always_ff @(posedge clk_sys) begin
        if (mif.cm_we) begin
            conn_mem[mif.cm_idx] <= mif.cm_entry;
        end
        if (mif.dm_we) begin
            data_mem[mif.dm_idx] <= mif.dm_byte;
        end
    end

    // ------------------------------------------------------------
    // read pipeline
    // ------------------------------------------------------------
    // [R3] entry by output slot, data by its source slot
    always_ff @(posedge clk_sys) begin
        entry_ff <= conn_mem[mif.rd_idx];
        dbyte_ff <= data_mem[lts_phys_idx(mif.rate, entry_ff[10:7], entry_ff[6:0])];
        entry2_ff <= entry_ff;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            v1_ff <= 1'b0;
            v2_ff <= 1'b0;
        end else begin
            v1_ff <= mif.rd_req;
            v2_ff <= v1_ff;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            valid_ff <= 1'b0;
            byte_ff <= 8'h00;
            oe_n_ff <= 1'b1;
            strobe_ff <= 1'b0;
            altbuf_ff <= 1'b0;
        end else begin
            valid_ff <= v2_ff;
            if (v2_ff) begin
                // [R16] pattern replaces memory data
                byte_ff <= entry2_ff[LTS_E_PATTERN] ? entry2_ff[7:0] : dbyte_ff;
                // [R15] disabled slot floats
                oe_n_ff <= ~entry2_ff[LTS_E_SLOT_OE];
                strobe_ff <= entry2_ff[LTS_E_XSTROBE];
                altbuf_ff <= entry2_ff[LTS_E_ALTBUF];
            end
        end
    end

    assign mif.rd_valid = valid_ff;
    assign mif.rd_byte = byte_ff;
    assign mif.rd_oe_n = oe_n_ff;
    assign mif.rd_strobe = strobe_ff;
    assign mif.rd_altbuf = altbuf_ff;
endmodule : lts_switch
`default_nettype wire

// file: src/lts_setup.sv
// local slot interchange: indirect connection setup and switching
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// [R1] Data and connection memories hold 1024 entries each, selected by a 10-bit index.
// [R2] An 11-bit stream and slot address from the host is turned into a physical index.
// [R3] Connection entries sit at the output slot; data entries at the input slot.
// [R4] A connection stores the source data location into the output slot's entry.
// [R5] The host writes the target slot in 7 bits of the slot register, 8 for pattern.
// [R6] The host puts the target stream in the low four mode bits.
// [R7] The upper mode bits pick which entry field the next indirect write updates.
// [R8] An entry holds 15 bits, so two field transfers fill it.
// [R9] Every field transfer goes through the indirect data register.
// [R10] The first data write carries the 7-bit slot part of the source location.
// [R11] Slot values map one-to-one, up to 0x1F, 0x3F or 0x7F by rate; beyond is refused.
// [R12] The host writes the fallback clock registers after all related registers.
// [R13] Second transfer: bit 7 strobe, 6 pattern, 5 alternate buffer, 4 output enable, 3-0 stream.
// [R14] All 15 bits reach connection memory only when the second transfer arrives.
// [R15] A slot whose output enable is low floats.
// [R16] In pattern mode the first transfer is a byte sent in place of memory data.
// [R17] The first field is held so an entry updates atomically.
module lts_setup
    import lts_pkg::*;
(
    input wire logic clk_sys, // 40 MHz system clock
    input wire logic rst, // sync reset, high
    input wire logic [1:0] rate_sel, // local stream rate
    input wire logic host_wr_slot, // write slot address reg
    input wire logic host_wr_mode, // write address mode reg
    input wire logic host_wr_data, // write indirect data reg
    input wire logic [7:0] host_wdata, // host write value
    output logic [7:0] local_slot_address_reg, // slot address readback
    output logic [7:0] address_mode_reg, // mode readback
    output logic [7:0] indirect_data_reg, // last data write
    output logic half_pending, // first field held
    output logic commit_pulse, // entry written
    output logic range_err, // sticky refused address
    input wire logic range_err_clr, // clear range_err
    input wire logic in_wr, // incoming byte strobe
    input wire logic [3:0] in_stream, // incoming stream
    input wire logic [6:0] in_slot, // incoming slot
    input wire logic [7:0] in_byte, // incoming byte
    input wire logic out_req, // output slot request
    input wire logic [3:0] out_stream, // output stream
    input wire logic [6:0] out_slot, // output slot
    output logic out_valid, // output result pulse
    output logic [7:0] out_byte, // switched byte
    output logic out_oe_n, // low drives the slot
    output logic external_strobe_bit, // strobe for slot
    output logic alternate_buffer_select // alt buffer for slot
);
    lts_mem_if mif ();

    lts_state_t state_ff;
    lts_state_t nxt_state;
    logic [7:0] slot_ff;
    logic [7:0] mode_ff;
    logic [7:0] idr_ff;
    logic [7:0] hold_ff;
    logic range_ff;
    logic commit_ff;
    logic cm_we_ff;
    logic [LTS_IDX_W-1:0] cm_idx_ff;
    logic [LTS_ENTRY_W-1:0] cm_entry_ff;
    logic dm_we_ff;
    logic [LTS_IDX_W-1:0] dm_idx_ff;
    logic [7:0] dm_byte_ff;
    logic [3:0] field_sel;
    logic [3:0] tgt_stream;
    logic tgt_ok;
    logic src_ok;
    logic is_pattern;
    logic wr_first;
    logic wr_second;
    logic do_commit;
    logic bad_addr;
    logic [LTS_ENTRY_W-1:0] new_entry;

    // ------------------------------------------------------------
    // host register file
    // ------------------------------------------------------------
    // [R5] slot address kept 8 bits wide for pattern
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            slot_ff <= LTS_SLOT_RST;
        end else if (host_wr_slot) begin
            slot_ff <= host_wdata;
        end
    end

    // [R6] stream in low nibble, field select above
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mode_ff <= LTS_MODE_RST;
        end else if (host_wr_mode) begin
            mode_ff <= host_wdata;
        end
    end

    // [R9] all field data arrives here
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            idr_ff <= 8'h00;
        end else if (host_wr_data) begin
            idr_ff <= host_wdata;
        end
    end

    // ------------------------------------------------------------
    // field decode and address checks
    // ------------------------------------------------------------
    // [R7] upper mode bits choose the field
    assign field_sel = mode_ff[LTS_MODE_FIELD_LSB +: 4];
    assign tgt_stream = mode_ff[LTS_MODE_STREAM_LSB +: 4];
    assign wr_first = host_wr_data && (field_sel == LTS_FIELD_SLOT);
    assign wr_second = host_wr_data && (field_sel == LTS_FIELD_CTRL);
    assign is_pattern = host_wdata[LTS_BIT_PATTERN];

    // [R11] slots beyond the rate's range are refused
    assign tgt_ok = lts_addr_ok(rate_sel, tgt_stream, slot_ff[6:0]);
    // pattern has no source to check
    assign src_ok = is_pattern ||
                    lts_addr_ok(rate_sel, host_wdata[LTS_SRC_STREAM_LSB +: 4], hold_ff[6:0]);
    assign do_commit = wr_second && tgt_ok && src_ok;
    assign bad_addr = wr_second && !(tgt_ok && src_ok);

    // ------------------------------------------------------------
    // first field holding register
    // ------------------------------------------------------------
    // [R17] held until the second transfer commits
    // [R10] first write is the source slot, or a pattern byte
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hold_ff <= LTS_HOLD_RST;
        end else if (wr_first) begin
            hold_ff <= host_wdata;
        end
    end

    // ------------------------------------------------------------
    // entry assembly
    // ------------------------------------------------------------
    // [R13] control nibble and source stream of second transfer
    // [R16] pattern byte fills the low 8 bits, over the stream lsb
    always_comb begin
        new_entry = '0;
        new_entry[6:0] = hold_ff[6:0];
        new_entry[7] = is_pattern ? hold_ff[7] : host_wdata[LTS_SRC_STREAM_LSB];
        new_entry[10:8] = host_wdata[LTS_SRC_STREAM_LSB + 1 +: 3];
        new_entry[LTS_E_XSTROBE] = host_wdata[LTS_BIT_XSTROBE];
        new_entry[LTS_E_PATTERN] = host_wdata[LTS_BIT_PATTERN];
        new_entry[LTS_E_ALTBUF] = host_wdata[LTS_BIT_ALTBUF];
        new_entry[LTS_E_SLOT_OE] = host_wdata[LTS_BIT_SLOT_OE];
    end

    // ------------------------------------------------------------
    // transfer sequencing
    // ------------------------------------------------------------
    // [R8] two transfers per entry
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            LTS_IDLE: begin
                if (wr_first) begin
                    nxt_state = LTS_HALF;
                end
            end
            LTS_HALF: begin
                if (wr_second) begin
                    nxt_state = LTS_IDLE;
                end
            end
            default: nxt_state = LTS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff <= LTS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // connection memory write
    // ------------------------------------------------------------
    // [R14] second transfer triggers the single 15-bit write
    // [R4] source location lands at the target slot's entry
    // [R2] stream and slot converted to a physical index
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cm_we_ff <= 1'b0;
            cm_idx_ff <= '0;
            cm_entry_ff <= '0;
            commit_ff <= 1'b0;
        end else begin
            cm_we_ff <= do_commit;
            commit_ff <= do_commit;
            if (do_commit) begin
                cm_idx_ff <= lts_phys_idx(rate_sel, tgt_stream, slot_ff[6:0]);
                cm_entry_ff <= new_entry;
            end
        end
    end

    // set wins over a same-cycle clear
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            range_ff <= 1'b0;
        end else if (bad_addr) begin
            range_ff <= 1'b1;
        end else if (range_err_clr) begin
            range_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // incoming data and output requests
    // ------------------------------------------------------------
    // [R3] incoming bytes stored at their input slot
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dm_we_ff <= 1'b0;
            dm_idx_ff <= '0;
            dm_byte_ff <= 8'h00;
        end else begin
            dm_we_ff <= in_wr && lts_addr_ok(rate_sel, in_stream, in_slot);
            dm_idx_ff <= lts_phys_idx(rate_sel, in_stream, in_slot);
            dm_byte_ff <= in_byte;
        end
    end

    assign mif.cm_we = cm_we_ff;
    assign mif.cm_idx = cm_idx_ff;
    assign mif.cm_entry = cm_entry_ff;
    assign mif.dm_we = dm_we_ff;
    assign mif.dm_idx = dm_idx_ff;
    assign mif.dm_byte = dm_byte_ff;
    assign mif.rd_req = out_req;
    assign mif.rd_idx = lts_phys_idx(rate_sel, out_stream, out_slot);
    assign mif.rate = rate_sel;

    lts_switch u_switch (
        .clk_sys(clk_sys),
        .rst(rst),
        .mif(mif)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign local_slot_address_reg = slot_ff;
    assign address_mode_reg = mode_ff;
    assign indirect_data_reg = idr_ff;
    assign half_pending = (state_ff == LTS_HALF);
    assign commit_pulse = commit_ff;
    assign range_err = range_ff;
    assign out_valid = mif.rd_valid;
    assign out_byte = mif.rd_byte;
    // [R15] high impedance when slot output is disabled
    assign out_oe_n = mif.rd_oe_n;
    assign external_strobe_bit = mif.rd_strobe;
    assign alternate_buffer_select = mif.rd_altbuf;
endmodule : lts_setup
`default_nettype wire

// file: testbench/lts_setup_asserts.sv
// port-level assertions for connection setup
`timescale 1ns/1ps
`default_nettype none
module lts_setup_asserts (
    input wire logic clk_sys, // system clock
    input wire logic rst, // sync reset
    input wire logic host_wr_slot, // slot strobe
    input wire logic host_wr_mode, // mode strobe
    input wire logic host_wr_data, // data strobe
    input wire logic [7:0] host_wdata, // write value
    input wire logic [7:0] local_slot_address_reg, // slot reg
    input wire logic [7:0] address_mode_reg, // mode reg
    input wire logic [7:0] indirect_data_reg, // data reg
    input wire logic half_pending, // first field held
    input wire logic commit_pulse, // entry written
    input wire logic range_err, // refused address
    input wire logic range_err_clr, // clear refusal
    input wire logic out_req, // read request
    input wire logic out_valid, // read result
    input wire logic out_oe_n, // slot drive
    input wire logic external_strobe_bit, // strobe bit
    input wire logic alternate_buffer_select // alt buffer
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // ----------------------------------------
    // host side
    // ----------------------------------------
    chk_slot_reg_load: assert property (host_wr_slot |=> local_slot_address_reg == $past(host_wdata))
        else $error("slot reg load");
    chk_mode_reg_load: assert property (host_wr_mode |=> address_mode_reg == $past(host_wdata))
        else $error("mode reg load");
    chk_data_reg_load: assert property (host_wr_data && address_mode_reg[7:5] == 3'h0 |=>
        indirect_data_reg == $past(host_wdata)) else $error("data reg load");
    chk_first_held: assert property (host_wr_data && address_mode_reg[7:4] == 4'h0 |=> half_pending)
        else $error("not held");
    chk_commit_cause: assert property (commit_pulse |-> $past(host_wr_data)
        && $past(address_mode_reg[7:4]) == 4'h1 && !half_pending) else $error("stray commit");
    chk_range_sticky: assert property (range_err && !range_err_clr |=> range_err)
        else $error("flag dropped");
    chk_range_cause: assert property ($rose(range_err) |-> $past(host_wr_data)
        && $past(address_mode_reg[7:4]) == 4'h1 && !commit_pulse) else $error("stray refusal");
    // ----------------------------------------
    // switching side
    // ----------------------------------------
    chk_read_latency: assert property (out_req |-> ##3 out_valid)
        else $error("late read");
    chk_read_cause: assert property (out_valid |-> $past(out_req, 3))
        else $error("stray read");
    chk_oe_with_read: assert property ($changed(out_oe_n) |-> out_valid)
        else $error("stray oe change");
    chk_ctl_with_read: assert property ($changed({external_strobe_bit, alternate_buffer_select}) |-> out_valid)
        else $error("stray ctl change");
    cov_commit: cover property (commit_pulse);
    cov_refuse: cover property ($rose(range_err));
    cov_drive: cover property (out_valid && !out_oe_n);
endmodule : lts_setup_asserts

bind lts_setup lts_setup_asserts u_chk (
    .clk_sys(clk_sys), .rst(rst), .host_wr_slot(host_wr_slot), .host_wr_mode(host_wr_mode),
    .host_wr_data(host_wr_data), .host_wdata(host_wdata), .local_slot_address_reg(local_slot_address_reg),
    .address_mode_reg(address_mode_reg), .indirect_data_reg(indirect_data_reg), .half_pending(half_pending),
    .commit_pulse(commit_pulse), .range_err(range_err), .range_err_clr(range_err_clr), .out_req(out_req),
    .out_valid(out_valid), .out_oe_n(out_oe_n), .external_strobe_bit(external_strobe_bit),
    .alternate_buffer_select(alternate_buffer_select)
);
`default_nettype wire

// file: testbench/lts_host_model.sv
// host model issuing indirect writes
`timescale 1ns/1ps
`default_nettype none
module lts_host_model (
    input wire logic clk_sys, // system clock
    output logic host_wr_slot, // slot reg strobe
    output logic host_wr_mode, // mode reg strobe
    output logic host_wr_data, // data reg strobe
    output logic [7:0] host_wdata // write value
);
    initial begin
        host_wr_slot = 1'b0;
        host_wr_mode = 1'b0;
        host_wr_data = 1'b0;
        host_wdata = 8'hFF;
    end
    // no fallback clock regs to order
    // kind 0 idle, 1 slot, 2 mode, 3 data
    task automatic put(input logic [1:0] kind, input logic [7:0] val);
        @(posedge clk_sys);
        #2;
        host_wr_slot = (kind == 2'h1);
        host_wr_mode = (kind == 2'h2);
        host_wr_data = (kind == 2'h3);
        host_wdata = val;
    endtask : put
    task automatic connect(input logic [7:0] tslot, input logic [3:0] tstream, input logic [7:0] first,
                           input logic [7:0] ctl);
        put(2'h1, tslot);
        put(2'h2, {4'h0, tstream});
        put(2'h3, first);
        put(2'h2, {4'h1, tstream});
        put(2'h3, ctl);
        put(2'h0, ~ctl);
    endtask : connect
endmodule : lts_host_model
`default_nettype wire

// file: testbench/lts_setup_test.sv
// self-checking bench for connection setup
`timescale 1ns/1ps
`default_nettype none
module lts_setup_test;
    import lts_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [1:0] rate_sel = LTS_RATE_8M;
    logic range_err_clr = 1'b0;
    logic in_wr = 1'b0;
    logic [3:0] in_stream = 4'h0;
    logic [6:0] in_slot = 7'h00;
    logic [7:0] in_byte = 8'h00;
    logic out_req = 1'b0;
    logic [3:0] out_stream = 4'h0;
    logic [6:0] out_slot = 7'h00;
    logic host_wr_slot, host_wr_mode, host_wr_data, half_pending, commit_pulse, range_err, out_valid;
    logic out_oe_n, external_strobe_bit, alternate_buffer_select;
    logic [7:0] host_wdata, local_slot_address_reg, address_mode_reg, indirect_data_reg, out_byte;
    logic [6:0] slot_max [3] = '{LTS_SLOT_MAX_2M, LTS_SLOT_MAX_4M, LTS_SLOT_MAX_8M};
    logic [7:0] bad_slot [3] = '{8'h20, 8'h40, 8'h00};
    logic [3:0] bad_stream [3] = '{4'h2, 4'h2, 4'h8};
    int errors = 0;
    int checks_done = 0;

    always #12.5 clk_sys = ~clk_sys;

    lts_setup DUT (.clk_sys(clk_sys), .rst(rst), .rate_sel(rate_sel), .host_wr_slot(host_wr_slot),
        .host_wr_mode(host_wr_mode), .host_wr_data(host_wr_data), .host_wdata(host_wdata),
        .local_slot_address_reg(local_slot_address_reg), .address_mode_reg(address_mode_reg),
        .indirect_data_reg(indirect_data_reg), .half_pending(half_pending), .commit_pulse(commit_pulse),
        .range_err(range_err), .range_err_clr(range_err_clr), .in_wr(in_wr), .in_stream(in_stream),
        .in_slot(in_slot), .in_byte(in_byte), .out_req(out_req), .out_stream(out_stream), .out_slot(out_slot),
        .out_valid(out_valid), .out_byte(out_byte), .out_oe_n(out_oe_n),
        .external_strobe_bit(external_strobe_bit), .alternate_buffer_select(alternate_buffer_select));
    lts_host_model host (.clk_sys(clk_sys), .host_wr_slot(host_wr_slot), .host_wr_mode(host_wr_mode),
        .host_wr_data(host_wr_data), .host_wdata(host_wdata));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_byte
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        cmp_byte(what, {7'h00, exp}, {7'h00, got});
    endtask : cmp_bit
    task automatic step();
        @(posedge clk_sys);
        #2;
    endtask : step
    task automatic data_in(input logic [3:0] s, input logic [6:0] t, input logic [7:0] b);
        step();
        in_wr = 1'b1;
        in_stream = s;
        in_slot = t;
        in_byte = b;
        step();
        in_wr = 1'b0;
    endtask : data_in
    // byte checked only while driven
    task automatic read_slot(input logic [3:0] s, input logic [6:0] t, input logic [7:0] eb, input logic eoe,
                             input logic exs, input logic ealt);
        int n;
        repeat (2) step();
        out_req = 1'b1;
        out_stream = s;
        out_slot = t;
        step();
        out_req = 1'b0;
        n = 0;
        do begin
            step();
            n++;
        end while (out_valid !== 1'b1 && n < 6);
        cmp_bit("out_valid", 1'b1, out_valid);
        if (out_valid !== 1'b1) begin
            give_verdict();
        end else begin
            if (eoe == 1'b0) cmp_byte("out_byte", eb, out_byte);
            cmp_bit("out_oe_n", eoe, out_oe_n);
            cmp_bit("strobe", exs, external_strobe_bit);
            cmp_bit("altbuf", ealt, alternate_buffer_select);
        end
    endtask : read_slot

    initial begin
        repeat (4) step();
        rst = 1'b0;
        cmp_byte("slot reg", 8'h00, local_slot_address_reg);
        cmp_byte("mode reg", 8'h00, address_mode_reg);
        cmp_bit("oe_n idle", 1'b1, out_oe_n);
        cmp_bit("half idle", 1'b0, half_pending);
        $display("test reset done");
        data_in(4'h3, 7'h7F, 8'hA5);
        host.connect(8'h05, 4'h7, 8'h7F, 8'h93);
        read_slot(4'h7, 7'h05, 8'hA5, 1'b0, 1'b1, 1'b0);
        cmp_byte("data reg", 8'h93, indirect_data_reg);
        $display("test connect done");
        data_in(4'h3, 7'h11, 8'h3C);
        host.put(2'h1, 8'h05);
        host.put(2'h2, 8'h07);
        host.put(2'h3, 8'h11);
        host.put(2'h0, 8'hFF);
        cmp_bit("half held", 1'b1, half_pending);
        read_slot(4'h7, 7'h05, 8'hA5, 1'b0, 1'b1, 1'b0);
        host.put(2'h2, 8'h17);
        host.put(2'h3, 8'h23);
        host.put(2'h0, 8'hFF);
        read_slot(4'h7, 7'h05, 8'h3C, 1'b1, 1'b0, 1'b1);
        $display("test atomic done");
        host.connect(8'h8A, 4'h2, 8'hC6, 8'h51);
        read_slot(4'h2, 7'h0A, 8'hC6, 1'b0, 1'b0, 1'b0);
        cmp_byte("slot reg", 8'h8A, local_slot_address_reg);
        host.put(2'h2, 8'h27);
        host.put(2'h3, 8'h01);
        host.put(2'h0, 8'hFF);
        cmp_bit("field ignored", 1'b0, half_pending);
        $display("test pattern done");
        for (int r = 0; r < 3; r++) begin
            rate_sel = r[1:0];
            data_in(4'h1, slot_max[r], 8'h10 + r[7:0]);
            host.connect({1'b0, slot_max[r]}, 4'h2, {1'b0, slot_max[r]}, 8'h11);
            read_slot(4'h2, slot_max[r], 8'h10 + r[7:0], 1'b0, 1'b0, 1'b0);
            host.connect(bad_slot[r], bad_stream[r], 8'h00, 8'h11);
            step();
            cmp_bit("range err", 1'b1, range_err);
            range_err_clr = 1'b1;
            step();
            range_err_clr = 1'b0;
            cmp_bit("range clr", 1'b0, range_err);
        end
        rate_sel = 2'h3;
        host.connect(8'h00, 4'h0, 8'h00, 8'h11);
        step();
        cmp_bit("rate refused", 1'b1, range_err);
        $display("test rates done");
        give_verdict();
    end
endmodule : lts_setup_test
`default_nettype wire
